// ---- cdcrb_cfg.svh ----
// Offsets, field positions, reset values and register count of the register bank
`ifndef CDCRB_CFG_SVH
`define CDCRB_CFG_SVH

`define CDCRB_ADDR_STATUS      5'h00
`define CDCRB_ADDR_CAP_H       5'h01
`define CDCRB_ADDR_CAP_M       5'h02
`define CDCRB_ADDR_CAP_L       5'h03
`define CDCRB_ADDR_VT_H        5'h04
`define CDCRB_ADDR_VT_M        5'h05
`define CDCRB_ADDR_VT_L        5'h06
`define CDCRB_ADDR_CAP_SETUP   5'h07
`define CDCRB_ADDR_VT_CHANNEL_SETUP    5'h08
`define CDCRB_ADDR_EXCITATION_SETUP   5'h09
`define CDCRB_ADDR_CONFIG      5'h0a
`define CDCRB_ADDR_DAC_A       5'h0b
`define CDCRB_ADDR_DAC_B       5'h0c
`define CDCRB_ADDR_OFF_H       5'h0d
`define CDCRB_ADDR_OFF_L       5'h0e
`define CDCRB_ADDR_CGAIN_H     5'h0f
`define CDCRB_ADDR_CGAIN_L     5'h10
`define CDCRB_ADDR_VGAIN_H     5'h11
`define CDCRB_ADDR_VGAIN_L     5'h12
`define CDCRB_ADDR_LAST        5'h12
`define CDCRB_RW_FIRST         5'h07
`define CDCRB_RW_COUNT         12

`define CDCRB_STATUS_RESET     8'h07
`define CDCRB_RESULT_RESET     24'h000000
`define CDCRB_CAP_SETUP_RESET  8'h00
`define CDCRB_VT_CHANNEL_SETUP_RESET   8'h00
`define CDCRB_EXCITATION_SETUP_RESET  8'h03
`define CDCRB_CONFIG_RESET     8'ha0
`define CDCRB_DAC_RESET        8'h00
`define CDCRB_OFF_H_RESET      8'h80
`define CDCRB_OFF_L_RESET      8'h00
`define CDCRB_TRIM_DEFAULT     8'h80

`define CDCRB_BIT_READY        2
`define CDCRB_BIT_VT_DONE      1
`define CDCRB_BIT_CAP_DONE     0
`define CDCRB_BIT_CHAN_EN      7

`endif

// ---- cdcrb_pkg.sv ----
// Types shared by the register bank modules
package cdcrb_pkg;
  // Byte access from the serial bus framer
  typedef struct packed {
    logic       start;     // Start or repeated start seen
    logic       stop;      // Stop seen
    logic       ptr_wr;    // Pointer byte received
    logic       data_wr;   // Data byte received
    logic       data_rd;   // Read byte fetched and acknowledged
    logic [7:0] wdata;
  } cdcrb_bus_t;

  // Finished conversion from the converter datapath
  typedef struct packed {
    logic        cap_done;
    logic [23:0] cap_data;
    logic        vt_done;
    logic [23:0] vt_data;
  } cdcrb_conv_t;

  typedef enum logic [1:0] {
    CDCRB_IDLE  = 2'b00,
    CDCRB_WRITE = 2'b01,
    CDCRB_READ  = 2'b10
  } cdcrb_phase_t;
endpackage

// ---- cdcrb_result_reg.sv ----
// One 24-bit conversion result register with its unread flag
`timescale 1ns/1ps
`include "cdcrb_cfg.svh"
module cdcrb_result_reg (
  input  wire logic        ref_clk,
  input  wire logic        reset_n,
  input  wire logic        done,
  input  wire logic [23:0] data_in,
  input  wire logic        hold,
  input  wire logic        read_ack,
  output logic [23:0]      data_out,
  output logic             done_n
);
  typedef struct packed {
    logic [23:0] data;
    logic        done_n;
  } cdcrb_res_st_t;

  cdcrb_res_st_t st_r;
  cdcrb_res_st_t st_nxt;

  // ----------------------------------------
  // Next state
  // ----------------------------------------
  always_comb begin
    st_nxt = st_r;
    if (read_ack) begin
      st_nxt.done_n = 1'b1;
    end
    // Capture beats the read clear; a result under a read is lost
    if (done && !hold) begin
      st_nxt.data   = data_in;
      st_nxt.done_n = 1'b0;
    end
  end

  // ----------------------------------------
  // State register
  // ----------------------------------------
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      st_r.data   <= `CDCRB_RESULT_RESET;
      st_r.done_n <= 1'b1;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign data_out = st_r.data;
  assign done_n   = st_r.done_n;
endmodule // cdcrb_result_reg

// ---- cdcrb_cfg_reg.sv ----
// One writable 8-bit setup register with a reset or trim load value
`timescale 1ns/1ps
`include "cdcrb_cfg.svh"
module cdcrb_cfg_reg (
  input  wire logic       ref_clk,
  input  wire logic       reset_n,
  input  wire logic       load_trim,
  input  wire logic [7:0] trim,
  input  wire logic       wr,
  input  wire logic [7:0] wdata,
  output logic [7:0]      q
);
  parameter logic [7:0] RESET_VAL = 8'h00;

  typedef struct packed {
    logic [7:0] val;
  } cdcrb_cfg_st_t;

  cdcrb_cfg_st_t st_r;
  cdcrb_cfg_st_t st_nxt;

  // ----------------------------------------
  // Next state: trim load once after reset, then master writes
  // ----------------------------------------
  always_comb begin
    st_nxt = st_r;
    if (load_trim) begin
      st_nxt.val = trim;
    end else if (wr) begin
      st_nxt.val = wdata;
    end
  end

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      st_r.val <= RESET_VAL;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign q = st_r.val;
endmodule // cdcrb_cfg_reg

// ---- cdcrb_bank.sv ----
// Register bank and conversion status logic of the capacitance converter
//
// How it works
// - The pointer is loaded by the master and never read back; all other registers read.
// - Each byte read or written moves the pointer on by one until the stop; at 0x1f it holds.
// - Status sits at 0x00, is read-only and resets to 0x07.
// - Status bits 7 to 3 always read zero.
// - Bit 2 goes low when a channel is enabled and every enabled channel has fresh unread data.
// - With both channels on, bit 2 falls only after both are done.
// - Bit 2 goes high on a data read or as the next conversion ends.
// - With one channel on, bit 2 follows that channel's flag.
// - Bit 1 goes low when a voltage/temperature result is fresh.
// - Bit 0 goes low when a capacitive result is fresh.
// - The ready pin mirrors bit 2.
// - A stop returns to idle and sets the pointer to 0x00.
// - Writes outside the map are acknowledged and dropped.
// - A result register is not updated while it is being read; that result is lost.
`timescale 1ns/1ps
`include "cdcrb_cfg.svh"
module cdcrb_bank (
  input  wire logic                 ref_clk,
  input  wire logic                 reset_n,
  input  wire cdcrb_pkg::cdcrb_bus_t  bus,
  input  wire cdcrb_pkg::cdcrb_conv_t conv,
  input  wire logic [7:0]           trim_cap_gain_h,
  input  wire logic [7:0]           trim_cap_gain_l,
  input  wire logic [7:0]           trim_volt_gain_h,
  input  wire logic [7:0]           trim_volt_gain_l,
  output logic [7:0]                rdata,
  output logic                      ready_n,
  output logic                      ready_oe,
  output logic                      cap_enable,
  output logic                      vt_enable
);
  import cdcrb_pkg::*;

  typedef struct packed {
    cdcrb_phase_t phase;
    logic [4:0]   ptr;
    logic         cap_busy;     // Cap result read since last stop
    logic         vt_busy;
    logic         ready_n;
    logic         trim_load;
    logic [7:0]   rdata;
    logic         ready_pin;
    logic         ready_oe;
    logic         cap_en;
    logic         vt_en;
  } cdcrb_bank_st_t;

  cdcrb_bank_st_t st_r;
  cdcrb_bank_st_t st_nxt;

  logic [23:0] cap_q;
  logic [23:0] vt_q;
  logic        cap_done_n;
  logic        vt_done_n;
  logic        cap_rd_ack;
  logic        vt_rd_ack;
  logic [7:0]  status;
  logic [7:0]  cfg_q [`CDCRB_RW_COUNT];
  logic [7:0]  trim_v [`CDCRB_RW_COUNT];
  logic        chan_en_cap;
  logic        chan_en_vt;
  logic        both_fresh;

  // ----------------------------------------
  // Result registers
  // ----------------------------------------
  // A read counts as consumed when a byte of it is acknowledged
  assign cap_rd_ack = bus.data_rd && st_r.ptr >= `CDCRB_ADDR_CAP_H && st_r.ptr <= `CDCRB_ADDR_CAP_L;
  assign vt_rd_ack  = bus.data_rd && st_r.ptr >= `CDCRB_ADDR_VT_H && st_r.ptr <= `CDCRB_ADDR_VT_L;

  cdcrb_result_reg u_cap_res (
    .ref_clk  (ref_clk),
    .reset_n  (reset_n),
    .done     (conv.cap_done),
    .data_in  (conv.cap_data),
    .hold     (st_r.cap_busy || cap_rd_ack),
    .read_ack (cap_rd_ack),
    .data_out (cap_q),
    .done_n   (cap_done_n)
  );

  cdcrb_result_reg u_vt_res (
    .ref_clk  (ref_clk),
    .reset_n  (reset_n),
    .done     (conv.vt_done),
    .data_in  (conv.vt_data),
    .hold     (st_r.vt_busy || vt_rd_ack),
    .read_ack (vt_rd_ack),
    .data_out (vt_q),
    .done_n   (vt_done_n)
  );

  // ----------------------------------------
  // Writable setup and calibration registers
  // ----------------------------------------
  // Only the four gain trims take a factory value; others keep their reset
  always_comb begin
    for (int i = 0; i < `CDCRB_RW_COUNT; i++) begin
      trim_v[i] = 8'h00;
    end
    trim_v[8]  = trim_cap_gain_h;
    trim_v[9]  = trim_cap_gain_l;
    trim_v[10] = trim_volt_gain_h;
    trim_v[11] = trim_volt_gain_l;
  end

  localparam logic [7:0] RST_VALS [`CDCRB_RW_COUNT] = '{
    `CDCRB_CAP_SETUP_RESET, `CDCRB_VT_CHANNEL_SETUP_RESET, `CDCRB_EXCITATION_SETUP_RESET,
    `CDCRB_CONFIG_RESET, `CDCRB_DAC_RESET, `CDCRB_DAC_RESET, `CDCRB_OFF_H_RESET,
    `CDCRB_OFF_L_RESET, `CDCRB_TRIM_DEFAULT, `CDCRB_TRIM_DEFAULT,
    `CDCRB_TRIM_DEFAULT, `CDCRB_TRIM_DEFAULT};

  genvar g;
  generate
    for (g = 0; g < `CDCRB_RW_COUNT; g++) begin : g_cfg
      cdcrb_cfg_reg #(.RESET_VAL(RST_VALS[g])) u_cfg (
        .ref_clk   (ref_clk),
        .reset_n   (reset_n),
        .load_trim (st_r.trim_load && g >= 8),
        .trim      (trim_v[g]),
        .wr        (bus.data_wr && st_r.ptr == 5'(g + `CDCRB_RW_FIRST)),
        .wdata     (bus.wdata),
        .q         (cfg_q[g])
      );
    end
  endgenerate

  // ----------------------------------------
  // Status flags
  // ----------------------------------------
  assign chan_en_cap = cfg_q[0][`CDCRB_BIT_CHAN_EN];
  assign chan_en_vt  = cfg_q[1][`CDCRB_BIT_CHAN_EN];
  assign both_fresh  = !cap_done_n && !vt_done_n;

  always_comb begin
    status = 8'h00;
    status[`CDCRB_BIT_CAP_DONE] = cap_done_n;
    status[`CDCRB_BIT_VT_DONE]  = vt_done_n;
    status[`CDCRB_BIT_READY]    = st_r.ready_n;
  end

  // ----------------------------------------
  // Pointer, phase and combined ready
  // ----------------------------------------
  always_comb begin
    st_nxt           = st_r;
    st_nxt.trim_load = 1'b0;
    st_nxt.cap_en    = chan_en_cap;
    st_nxt.vt_en     = chan_en_vt;
    st_nxt.ready_oe  = 1'b1;

    // Combined flag; a new conversion end rearms it, reads clear it
    if (chan_en_cap && chan_en_vt) begin
      st_nxt.ready_n = !both_fresh;
    end else if (chan_en_cap) begin
      st_nxt.ready_n = cap_done_n;
    end else if (chan_en_vt) begin
      st_nxt.ready_n = vt_done_n;
    end else begin
      st_nxt.ready_n = 1'b1;
    end
    if (cap_rd_ack || vt_rd_ack) begin
      st_nxt.ready_n = 1'b1;
    end
    // A result ending on unread data lifts the flag for a cycle, so the pin falls again
    if ((conv.cap_done && st_r.cap_en) || (conv.vt_done && st_r.vt_en)) begin
      st_nxt.ready_n = 1'b1;
    end
    st_nxt.ready_pin = st_nxt.ready_n;

    case (st_r.phase)
      CDCRB_IDLE: begin
        if (bus.ptr_wr) begin
          st_nxt.phase = CDCRB_WRITE;
        end else if (bus.data_rd) begin
          st_nxt.phase = CDCRB_READ;
        end
      end
      CDCRB_WRITE: begin
        if (bus.data_rd) begin
          st_nxt.phase = CDCRB_READ;
        end
      end
      CDCRB_READ: begin
        if (bus.ptr_wr) begin
          st_nxt.phase = CDCRB_WRITE;
        end
      end
      default: st_nxt.phase = CDCRB_IDLE;
    endcase

    // Pointer load and auto-increment; it is never put on rdata
    if (bus.ptr_wr) begin
      st_nxt.ptr = bus.wdata[4:0];
      if (bus.wdata[7:5] != 3'b000) begin
        st_nxt.ptr = 5'h1f;                        // Out of map, kept invalid
      end
    end else if (bus.data_wr || bus.data_rd) begin
      if (st_r.ptr != 5'h1f) begin
        st_nxt.ptr = st_r.ptr + 5'h01;
      end
    end

    if (cap_rd_ack) begin
      st_nxt.cap_busy = 1'b1;
    end
    if (vt_rd_ack) begin
      st_nxt.vt_busy = 1'b1;
    end

    if (bus.stop) begin
      st_nxt.phase    = CDCRB_IDLE;
      st_nxt.ptr      = `CDCRB_ADDR_STATUS;
      st_nxt.cap_busy = 1'b0;
      st_nxt.vt_busy  = 1'b0;
    end

    // Read data for the byte at the pointer the next request will fetch
    if (st_nxt.ptr == `CDCRB_ADDR_STATUS) begin
      st_nxt.rdata = status;
    end else if (st_nxt.ptr == `CDCRB_ADDR_CAP_H) begin
      st_nxt.rdata = cap_q[23:16];
    end else if (st_nxt.ptr == `CDCRB_ADDR_CAP_M) begin
      st_nxt.rdata = cap_q[15:8];
    end else if (st_nxt.ptr == `CDCRB_ADDR_CAP_L) begin
      st_nxt.rdata = cap_q[7:0];
    end else if (st_nxt.ptr == `CDCRB_ADDR_VT_H) begin
      st_nxt.rdata = vt_q[23:16];
    end else if (st_nxt.ptr == `CDCRB_ADDR_VT_M) begin
      st_nxt.rdata = vt_q[15:8];
    end else if (st_nxt.ptr == `CDCRB_ADDR_VT_L) begin
      st_nxt.rdata = vt_q[7:0];
    end else if (st_nxt.ptr <= `CDCRB_ADDR_LAST) begin
      st_nxt.rdata = cfg_q[4'(st_nxt.ptr - `CDCRB_RW_FIRST)];
    end else begin
      st_nxt.rdata = 8'h00;
    end
  end

  // ----------------------------------------
  // State register
  // ----------------------------------------
  // Trim load is requested in the first cycle after reset release
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      st_r.phase     <= CDCRB_IDLE;
      st_r.ptr       <= `CDCRB_ADDR_STATUS;
      st_r.cap_busy  <= 1'b0;
      st_r.vt_busy   <= 1'b0;
      st_r.ready_n   <= 1'b1;
      st_r.trim_load <= 1'b1;
      st_r.rdata     <= `CDCRB_STATUS_RESET;
      st_r.ready_pin <= 1'b1;
      st_r.ready_oe  <= 1'b1;
      st_r.cap_en    <= 1'b0;
      st_r.vt_en     <= 1'b0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign rdata      = st_r.rdata;
  assign ready_n    = st_r.ready_pin;
  assign ready_oe   = st_r.ready_oe;
  assign cap_enable = st_r.cap_en;
  assign vt_enable  = st_r.vt_en;
endmodule // cdcrb_bank

// ---- cdcrb_monitor.sv ----
// Port checker of the register bank, bound to its top module
`timescale 1ns/1ps
module cdcrb_monitor (
  input wire logic                   ref_clk,
  input wire logic                   reset_n,
  input wire cdcrb_pkg::cdcrb_bus_t  bus,
  input wire cdcrb_pkg::cdcrb_conv_t conv,
  input wire logic [7:0]             rdata,
  input wire logic                   ready_n,
  input wire logic                   ready_oe,
  input wire logic                   cap_enable,
  input wire logic                   vt_enable
);
  import cdcrb_pkg::*;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!reset_n);
  // ----------------------------------------
  // Shadow pointer and read hold
  // ----------------------------------------
  logic [4:0] ptr_r;
  logic       hold_r;
  // Hold is kept wide (any read) so a dropped result never trips a check
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      ptr_r  <= 5'h00;
      hold_r <= 1'b0;
    end else begin
      if (bus.stop) ptr_r <= 5'h00;
      else if (bus.ptr_wr) ptr_r <= (|bus.wdata[7:5]) ? 5'h1f : bus.wdata[4:0];
      else if ((bus.data_rd || bus.data_wr) && ptr_r != 5'h1f) ptr_r <= ptr_r + 5'h01;
      hold_r <= bus.stop ? 1'b0 : (hold_r || bus.data_rd);
    end
  end
  property p_reset; $rose(reset_n) |-> rdata == 8'h07 && ready_n; endproperty
  a_reset: assert property (p_reset) else $error("status or pin wrong after reset");
  property p_oe; ready_oe; endproperty
  a_oe: assert property (p_oe) else $error("ready pin not driven");
  property p_stop; bus.stop |=> rdata[7:3] == 5'h00; endproperty
  a_stop: assert property (p_stop) else $error("status upper bits not zero after stop");
  property p_pin; bus.stop |=> ##[0:1] rdata[2] == ready_n; endproperty
  a_pin: assert property (p_pin) else $error("ready pin differs from status bit");
  property p_cap;
    conv.cap_done && cap_enable && !vt_enable && !hold_r && !bus.data_rd ##1 !bus.data_rd |-> ##[0:2] !ready_n;
  endproperty
  a_cap: assert property (p_cap) else $error("ready did not follow capacitive flag");
  sequence s_vt;
    conv.vt_done && ptr_r == 5'h00 && !hold_r && !(bus.ptr_wr || bus.data_rd || bus.data_wr)
      ##1 !(bus.ptr_wr || bus.data_rd || bus.data_wr);
  endsequence
  property p_vt; s_vt |-> ##[0:1] !rdata[1]; endproperty
  a_vt: assert property (p_vt) else $error("voltage flag not low");
  property p_rdclr;
    bus.data_rd && ((ptr_r inside {[5'h01:5'h03]} && !vt_enable) ||
                    (ptr_r inside {[5'h04:5'h06]} && !cap_enable)) |-> ##[1:3] ready_n;
  endproperty
  a_rdclr: assert property (p_rdclr) else $error("ready not released by data read");
  property p_noen; (!cap_enable && !vt_enable) [*3] |-> ready_n; endproperty
  a_noen: assert property (p_noen) else $error("ready low with no channel enabled");
  property p_rearm; (conv.cap_done && cap_enable) || (conv.vt_done && vt_enable) |=> ready_n; endproperty
  a_rearm: assert property (p_rearm) else $error("ready not raised as a new result ends");
  c_both: cover property (conv.cap_done && cap_enable && vt_enable);
  c_wr: cover property (bus.data_wr && ptr_r == 5'h12);
  c_fall: cover property ($fell(ready_n));
endmodule // cdcrb_monitor

bind cdcrb_bank cdcrb_monitor i_mon (.ref_clk, .reset_n, .bus, .conv, .rdata, .ready_n,
  .ready_oe, .cap_enable, .vt_enable);

// ---- cdcrb_host_model.sv ----
// Bus master and converter stand-in that drive the register bank
`timescale 1ns/1ps
module cdcrb_host_model (
  input  wire logic        ref_clk,
  input  wire logic [7:0]  rdata,
  output cdcrb_pkg::cdcrb_bus_t  bus,
  output cdcrb_pkg::cdcrb_conv_t conv
);
  import cdcrb_pkg::*;
  // ----------------------------------------
  // Strobes
  // ----------------------------------------
  initial begin
    bus = '0;
    conv = '0;
  end
  // One strobe cycle; released data turns to its inverse so stale bytes never match
  task automatic strobe(input logic [4:0] s, input logic [7:0] d);
    @(posedge ref_clk);
    bus <= {s, d};
    @(posedge ref_clk);
    bus <= {5'h00, ~d};
  endtask
  // Transfers open with a start and the pointer byte
  task automatic open_at(input logic [7:0] p);
    strobe(5'h10, 8'h00);
    strobe(5'h04, p);
  endtask
  // Byte is taken mid-cycle, then acknowledged
  task automatic rd(output logic [7:0] d);
    @(negedge ref_clk);
    d = rdata;
    strobe(5'h01, 8'h00);
  endtask
  // Finished conversion on one channel, one cycle long
  task automatic done(input logic cap, input logic [23:0] d);
    @(posedge ref_clk);
    conv <= cap ? {1'b1, d, 1'b0, ~d} : {1'b0, ~d, 1'b1, d};
    @(posedge ref_clk);
    conv <= {1'b0, ~d, 1'b0, d};
  endtask
endmodule // cdcrb_host_model

// ---- tb.sv ----
// Self-checking bench of the register bank
`timescale 1ns/1ps
module tb;
  import cdcrb_pkg::*;
  logic        ref_clk;
  logic        reset_n;
  cdcrb_bus_t  bus;
  cdcrb_conv_t conv;
  logic [7:0]  rdata;
  logic        ready_n;
  logic        ready_oe;
  logic        cap_enable;
  logic        vt_enable;
  int          failures = 0;
  int          checks = 0;
  // ----------------------------------------
  // Harness
  // ----------------------------------------
  cdcrb_bank i_dut (.ref_clk(ref_clk), .reset_n(reset_n), .bus(bus), .conv(conv),
    .trim_cap_gain_h(8'h5a), .trim_cap_gain_l(8'h3c), .trim_volt_gain_h(8'hc3),
    .trim_volt_gain_l(8'ha5), .rdata(rdata), .ready_n(ready_n), .ready_oe(ready_oe),
    .cap_enable(cap_enable), .vt_enable(vt_enable));
  cdcrb_host_model i_host (.ref_clk(ref_clk), .rdata(rdata), .bus(bus), .conv(conv));
  initial begin
    ref_clk = 1'b0;
    forever #20 ref_clk = ~ref_clk;
  end
  task automatic cmp(input string what, input logic [7:0] exp, input logic [7:0] got);
    checks++;
    if (got !== exp) begin
      failures++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask
  // Pointer 0xff means poll from wherever the last stop left the pointer
  task automatic rd_cmp(input logic [7:0] p, input logic [7:0] e[$]);
    logic [7:0] d;
    if (p == 8'hff) i_host.strobe(5'h10, 8'h00);
    else i_host.open_at(p);
    foreach (e[i]) begin
      i_host.rd(d);
      cmp($sformatf("reg %h", p + 8'(i)), e[i], d);
    end
    i_host.strobe(5'h08, 8'h00);
  endtask
  task automatic wr_all(input logic [7:0] p, input logic [7:0] d[$]);
    i_host.open_at(p);
    foreach (d[i]) i_host.strobe(5'h02, d[i]);
    i_host.strobe(5'h08, 8'h00);
  endtask
  task automatic pin(input logic exp);
    repeat (4) @(posedge ref_clk); // Flags settle well inside four cycles
    @(negedge ref_clk);
    cmp("ready_n", {7'h00, exp}, {7'h00, ready_n});
  endtask
  task automatic t_reset();
    pin(1'b1);
    rd_cmp(8'h00, '{8'h07, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h03,
      8'ha0, 8'h00, 8'h00, 8'h80, 8'h00, 8'h5a, 8'h3c, 8'hc3, 8'ha5});
  endtask
  task automatic t_rw();
    logic [7:0] q[$];
    logic [7:0] e[$];
    for (int i = 0; i < 11; i++) q.push_back(8'h30 + 8'(i));
    e = '{8'h00, 8'h00, 8'h00, 8'h21};
    e = {e, q};
    wr_all(8'h05, '{8'hee, 8'hee, 8'h21});
    wr_all(8'h08, q);
    wr_all(8'h13, '{8'hee});
    rd_cmp(8'h04, e);
  endtask
  // A result landing mid-read is lost and the flag stays clear
  task automatic t_cap();
    logic [7:0] d;
    wr_all(8'h07, '{8'ha0, 8'h00});
    cmp("cap_enable", 8'h01, {7'h00, cap_enable});
    i_host.done(1'b1, 24'habcdef);
    pin(1'b0);
    rd_cmp(8'hff, '{8'h02});
    i_host.open_at(8'h01);
    i_host.rd(d);
    cmp("cap high", 8'hab, d);
    i_host.done(1'b1, 24'h123456);
    i_host.rd(d);
    cmp("cap mid", 8'hcd, d);
    i_host.rd(d);
    cmp("cap low", 8'hef, d);
    i_host.strobe(5'h08, 8'h00);
    pin(1'b1);
    rd_cmp(8'h01, '{8'hab, 8'hcd, 8'hef});
    rd_cmp(8'h00, '{8'h07});
  endtask
  task automatic t_both();
    wr_all(8'h08, '{8'h80});
    cmp("vt_enable", 8'h01, {7'h00, vt_enable});
    i_host.done(1'b1, 24'h111111);
    pin(1'b1);
    rd_cmp(8'hff, '{8'h06});
    i_host.done(1'b0, 24'h654321);
    pin(1'b0);
    rd_cmp(8'hff, '{8'h00});
    rd_cmp(8'h04, '{8'h65, 8'h43, 8'h21});
    pin(1'b1);
    i_host.done(1'b0, 24'h0f0f0f);
    pin(1'b0);
    i_host.done(1'b1, 24'h222222);
    pin(1'b0);
    rd_cmp(8'h01, '{8'h22, 8'h22, 8'h22});
    pin(1'b1);
  endtask
  // Reset in mid-run clears the flags, parks the pointer and reloads the gain trims
  task automatic t_rst2();
    @(posedge ref_clk);
    reset_n <= 1'b0;
    repeat (2) @(posedge ref_clk);
    reset_n <= 1'b1;
    repeat (2) @(posedge ref_clk);
    pin(1'b1);
    rd_cmp(8'hff, '{8'h07});
    rd_cmp(8'h07, '{8'h00, 8'h00, 8'h03, 8'ha0, 8'h00, 8'h00, 8'h80, 8'h00, 8'h5a, 8'h3c,
      8'hc3, 8'ha5});
  endtask
  task automatic stop_test();
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  // Whole run is under two thousand cycles
  initial begin
    #400us;
    failures++;
    stop_test();
  end
  initial begin
    reset_n = 1'b0;
    repeat (4) @(posedge ref_clk);
    reset_n <= 1'b1;
    repeat (2) @(posedge ref_clk);
    t_reset();
    t_rw();
    t_cap();
    t_both();
    t_rst2();
    stop_test();
  end
endmodule // tb
